/* include/pfir_pkg.sv */
package pfir_pkg;

    localparam int unsigned REG_W  = 8;
    localparam int unsigned ADDR_W = 8;

    // register offsets
    localparam logic [7:0] STAT0_OFS  = 8'h05;
    localparam logic [7:0] MASK0_OFS  = 8'h06;
    localparam logic [7:0] SENSE0_OFS = 8'h07;
    localparam logic [7:0] STAT1_OFS  = 8'h08;
    localparam logic [7:0] MASK1_OFS  = 8'h09;
    localparam logic [7:0] SENSE1_OFS = 8'h0a;
    localparam logic [7:0] STAT3_OFS  = 8'h0e;
    localparam logic [7:0] MASK3_OFS  = 8'h0f;
    localparam logic [7:0] SENSE3_OFS = 8'h10;
    localparam logic [7:0] STAT4_OFS  = 8'h11;
    localparam logic [7:0] MASK4_OFS  = 8'h12;
    localparam logic [7:0] SENSE4_OFS = 8'h13;

    // group 0 field positions
    localparam int unsigned TEST_PIN_BIT   = 7;
    localparam int unsigned TEMP_HI4_BIT   = 5;
    localparam int unsigned TEMP_HI3_BIT   = 4;
    localparam int unsigned TEMP_HI2_BIT   = 3;
    localparam int unsigned TEMP_HI1_BIT   = 2;
    localparam int unsigned UNDERVOLT_BIT  = 1;
    localparam int unsigned POWER_KEY_BIT  = 0;

    // group 1 field positions
    localparam int unsigned BUCK3_BIT = 4;
    localparam int unsigned BUCK2_BIT = 3;
    localparam int unsigned BUCK1_BIT = 0;

    // group 3 field position
    localparam int unsigned OVERVOLT_BIT = 2;

    // bits that exist in each flag group
    localparam logic [7:0] GROUP0_BITS = 8'h3f;
    localparam logic [7:0] GROUP1_BITS = 8'h19;
    localparam logic [7:0] GROUP3_BITS = 8'h04;
    localparam logic [7:0] GROUP4_BITS = 8'h3f;

    // values after reset
    localparam logic [7:0] STAT_RESET  = 8'h00;
    localparam logic [7:0] MASK0_RESET = 8'h3f;
    localparam logic [7:0] MASK1_RESET = 8'h19;
    localparam logic [7:0] MASK3_RESET = 8'h04;
    localparam logic [7:0] MASK4_RESET = 8'h3f;
    localparam logic [7:0] RDATA_RESET = 8'h00;

endpackage : pfir_pkg

/* design/pfir_flag_bank.sv */
`timescale 1ns/1ps
`default_nettype none

module pfir_flag_bank #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] setVec,
    input  wire logic [W-1:0] clearVec,
    output var  logic [W-1:0] flags
);

    // sticky flags: a set in the clearing cycle keeps the flag
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clearVec) | setVec;
        end
    end

endmodule : pfir_flag_bank

`default_nettype wire

/* design/pfir_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - sense0 bit 7 reads live factory test pin level
// - sense0 bits 5..2 read live die temperature threshold comparisons
// - sense0 bit 1 reads 1 while input supply is below 2.7 V
// - sense0 bit 0 follows power key pin level
// - sense bits have no reset value, they show their sources
// - sense registers are read-only and return present state
// - status1 bits 4, 3, 0 set on buck3, buck2, buck1 current limit
// - status flags stay set until written 1; writing 0 does nothing
// - mask 0 lets a flag reach the interrupt pin, mask 1 blocks it
// - mask1 bits 4, 3, 0 mask buck3, buck2, buck1 overcurrent flags
// - sense1 bits 4, 3, 0 read live buck overcurrent state
// - overvoltage status bit 2 sets on input overvoltage, w1c
// - overvoltage mask bit 2 masks the overvoltage flag
// - overvoltage sense bit 2 reads live overvoltage state
// - linear fault status holds six sticky w1c flags
// - thermal flags set on threshold crossing either direction
// - power on flag sets on each turn-on event
module pfir_regs (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic [pfir_pkg::ADDR_W-1:0] regAddr,
    input  wire logic                      regWrEn,
    input  wire logic [pfir_pkg::REG_W-1:0]  regWrData,
    input  wire logic                      regRdEn,
    output var  logic [pfir_pkg::REG_W-1:0]  regRdData,
    output var  logic                      regRdValid,
    input  wire logic                      factoryTestPin,
    input  wire logic [3:0]                tempAbove,
    input  wire logic                      inputUndervolt,
    input  wire logic                      powerKeyPin,
    input  wire logic [2:0]                buckOvercurrent,
    input  wire logic                      inputOvervolt,
    input  wire logic [5:0]                linearOvercurrent,
    output var  logic                      irqOutN
);
    import pfir_pkg::*;

    function automatic logic [7:0] w1cVec(input logic [7:0] ofs,
                                          input logic [7:0] bits);
        w1cVec = (regWrEn && regAddr == ofs) ? (regWrData & bits) : 8'h00;
    endfunction : w1cVec

    function automatic logic isWrite(input logic [7:0] ofs);
        isWrite = regWrEn && (regAddr == ofs);
    endfunction : isWrite

    logic [7:0] sense0;
    logic [7:0] sense1;
    logic [7:0] sense3;
    logic [7:0] sense4;
    logic [7:0] set0;
    logic [7:0] set1;
    logic [7:0] set3;
    logic [7:0] set4;
    logic [7:0] stat0;
    logic [7:0] stat1;
    logic [7:0] stat3;
    logic [7:0] stat4;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] mask3;
    logic [7:0] mask4;
    logic [3:0] tempPrev;
    logic       keyPrev;
    logic       prevValid;
    logic       anyPending;
    logic [7:0] next_rdData;
    logic [7:0] clr0;
    logic [7:0] clr1;
    logic [7:0] clr3;
    logic [7:0] clr4;

    // live sense vectors, straight from the sources
    always_comb begin
        sense0 = 8'h00;
        sense0[TEST_PIN_BIT] = factoryTestPin;
        sense0[TEMP_HI4_BIT] = tempAbove[3];
        sense0[TEMP_HI3_BIT] = tempAbove[2];
        sense0[TEMP_HI2_BIT] = tempAbove[1];
        sense0[TEMP_HI1_BIT] = tempAbove[0];
        sense0[UNDERVOLT_BIT] = inputUndervolt;
        sense0[POWER_KEY_BIT] = powerKeyPin;
        sense1 = 8'h00;
        sense1[BUCK3_BIT] = buckOvercurrent[2];
        sense1[BUCK2_BIT] = buckOvercurrent[1];
        sense1[BUCK1_BIT] = buckOvercurrent[0];
        sense3 = 8'h00;
        sense3[OVERVOLT_BIT] = inputOvervolt;
        sense4 = {2'b00, linearOvercurrent};
    end

    // previous samples for edge-set flags; no edge until one is held
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tempPrev  <= 4'h0;
            keyPrev   <= 1'b0;
            prevValid <= 1'b0;
        end else begin
            tempPrev  <= tempAbove;
            keyPrev   <= powerKeyPin;
            prevValid <= 1'b1;
        end
    end

    always_comb begin
        set0 = 8'h00;
        if (prevValid) begin
            set0[TEMP_HI4_BIT:TEMP_HI1_BIT] = tempAbove ^ tempPrev;
            set0[POWER_KEY_BIT] = powerKeyPin & ~keyPrev;
        end
        set0[UNDERVOLT_BIT] = inputUndervolt;
        set1 = sense1;
        set3 = sense3;
        set4 = sense4;
    end

    // clear vectors in a process, so a bus change re-evaluates them
    always_comb begin
        clr0 = w1cVec(STAT0_OFS, GROUP0_BITS);
        clr1 = w1cVec(STAT1_OFS, GROUP1_BITS);
        clr3 = w1cVec(STAT3_OFS, GROUP3_BITS);
        clr4 = w1cVec(STAT4_OFS, GROUP4_BITS);
    end

    pfir_flag_bank #(.W(8)) u_stat0 (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .setVec   (set0),
        .clearVec (clr0),
        .flags    (stat0)
    );

    pfir_flag_bank #(.W(8)) u_stat1 (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .setVec   (set1),
        .clearVec (clr1),
        .flags    (stat1)
    );

    pfir_flag_bank #(.W(8)) u_stat3 (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .setVec   (set3),
        .clearVec (clr3),
        .flags    (stat3)
    );

    pfir_flag_bank #(.W(8)) u_stat4 (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .setVec   (set4),
        .clearVec (clr4),
        .flags    (stat4)
    );

    // mask registers; unused bits stay zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask0 <= MASK0_RESET;
            mask1 <= MASK1_RESET;
            mask3 <= MASK3_RESET;
            mask4 <= MASK4_RESET;
        end else begin
            if (isWrite(MASK0_OFS)) begin
                mask0 <= regWrData & GROUP0_BITS;
            end
            if (isWrite(MASK1_OFS)) begin
                mask1 <= regWrData & GROUP1_BITS;
            end
            if (isWrite(MASK3_OFS)) begin
                mask3 <= regWrData & GROUP3_BITS;
            end
            if (isWrite(MASK4_OFS)) begin
                mask4 <= regWrData & GROUP4_BITS;
            end
        end
    end

    assign anyPending = |(stat0 & ~mask0) | |(stat1 & ~mask1)
                      | |(stat3 & ~mask3) | |(stat4 & ~mask4);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqOutN <= 1'b1;
        end else begin
            irqOutN <= ~anyPending;
        end
    end

    // read mux; sense reads sample the live vector, writes to them do nothing
    always_comb begin
        case (regAddr)
            STAT0_OFS:  next_rdData = stat0;
            MASK0_OFS:  next_rdData = mask0;
            SENSE0_OFS: next_rdData = sense0;
            STAT1_OFS:  next_rdData = stat1;
            MASK1_OFS:  next_rdData = mask1;
            SENSE1_OFS: next_rdData = sense1;
            STAT3_OFS:  next_rdData = stat3;
            MASK3_OFS:  next_rdData = mask3;
            SENSE3_OFS: next_rdData = sense3;
            STAT4_OFS:  next_rdData = stat4;
            MASK4_OFS:  next_rdData = mask4;
            SENSE4_OFS: next_rdData = sense4;
            default:    next_rdData = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData  <= RDATA_RESET;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= next_rdData;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_read(logic [7:0] ofs);
        regRdEn && !regWrEn && regAddr == ofs;
    endsequence

    sequence s_clear1(int unsigned b);
        isWrite(STAT1_OFS) && regWrData[b] && !buckOvercurrent[0];
    endsequence

    a_testpin_live: assert property (s_read(SENSE0_OFS) |=>
        regRdValid && regRdData[TEST_PIN_BIT] == $past(factoryTestPin))
        else $error("test pin sense wrong");

    a_temp_live: assert property (s_read(SENSE0_OFS) |=>
        regRdData[TEMP_HI4_BIT:TEMP_HI1_BIT] == $past(tempAbove))
        else $error("temperature sense wrong");

    a_undervolt_live: assert property (s_read(SENSE0_OFS) |=>
        regRdData[UNDERVOLT_BIT] == $past(inputUndervolt)
        && regRdData[POWER_KEY_BIT] == $past(powerKeyPin))
        else $error("undervolt or key sense wrong");

    a_buck_sense: assert property (s_read(SENSE1_OFS) |=>
        regRdData == {3'b000, $past(buckOvercurrent[2]),
                      $past(buckOvercurrent[1]), 2'b00,
                      $past(buckOvercurrent[0])})
        else $error("buck sense wrong");

    a_buck_flag_set: assert property (buckOvercurrent[2] |=>
        stat1[BUCK3_BIT] ##1 (stat1[BUCK3_BIT] || $past(isWrite(STAT1_OFS))))
        else $error("buck3 flag not set");

    a_flag_w1c: assert property (s_clear1(BUCK1_BIT) |=>
        !stat1[BUCK1_BIT])
        else $error("write one did not clear");

    a_flag_hold: assert property (stat1[BUCK1_BIT] &&
        !(isWrite(STAT1_OFS) && regWrData[BUCK1_BIT]) |=> stat1[BUCK1_BIT])
        else $error("flag lost without write one");

    a_set_wins: assert property (isWrite(STAT3_OFS) &&
        regWrData[OVERVOLT_BIT] && inputOvervolt |=> stat3[OVERVOLT_BIT])
        else $error("set lost to clear");

    a_therm_edge: assert property (prevValid &&
        tempAbove[0] != $past(tempAbove[0]) |=> stat0[TEMP_HI1_BIT])
        else $error("thermal crossing missed");

    a_linear_flag: assert property (linearOvercurrent[5] |=>
        stat4[5])
        else $error("linear flag not set");

    a_irq_pin: assert property (##1 irqOutN ==
        !($past(|(stat1 & ~mask1)) || $past(|(stat0 & ~mask0))
          || $past(|(stat3 & ~mask3)) || $past(|(stat4 & ~mask4))))
        else $error("interrupt pin wrong");

    a_mask_blocks: assert property (mask3[OVERVOLT_BIT] &&
        stat0 == 8'h00 && stat1 == 8'h00 && stat4 == 8'h00 |=> irqOutN)
        else $error("masked flag reached pin");

    sequence s_wr_one(logic [7:0] ofs, int unsigned b);
        isWrite(ofs) && regWrData[b];
    endsequence

    a_rd_valid: assert property (regRdEn |=>
        regRdValid)
        else $error("read valid missing");

    a_rd_idle: assert property (!regRdEn |=>
        !regRdValid)
        else $error("read valid without read");

    a_ov_sense: assert property (s_read(SENSE3_OFS) |=>
        regRdData == {5'b00000, $past(inputOvervolt), 2'b00})
        else $error("overvoltage sense wrong");

    a_ov_set: assert property (inputOvervolt |=>
        stat3[OVERVOLT_BIT])
        else $error("overvoltage flag not set");

    a_ov_clear: assert property (s_wr_one(STAT3_OFS, OVERVOLT_BIT)
        ##0 !inputOvervolt |=> !stat3[OVERVOLT_BIT])
        else $error("overvoltage flag not cleared");

    a_buck2_set: assert property (buckOvercurrent[1] |=>
        stat1[BUCK2_BIT])
        else $error("buck2 flag not set");

    a_buck1_set: assert property (buckOvercurrent[0] |=>
        stat1[BUCK1_BIT])
        else $error("buck1 flag not set");

    a_mask1_write: assert property (isWrite(MASK1_OFS) |=>
        mask1 == ($past(regWrData) & GROUP1_BITS))
        else $error("buck mask write lost");

    a_mask3_write: assert property (isWrite(MASK3_OFS) |=>
        mask3 == ($past(regWrData) & GROUP3_BITS))
        else $error("overvoltage mask write lost");

    a_key_edge: assert property (prevValid && powerKeyPin &&
        !$past(powerKeyPin) |=> stat0[POWER_KEY_BIT])
        else $error("power key flag not set");

    a_uv_flag: assert property (inputUndervolt |=>
        stat0[UNDERVOLT_BIT])
        else $error("undervolt flag not set");

    a_ov_irq: assert property (stat3[OVERVOLT_BIT] &&
        !mask3[OVERVOLT_BIT] |=> !irqOutN)
        else $error("unmasked overvoltage not on pin");

    a_buck_irq: assert property (stat1[BUCK1_BIT] &&
        !mask1[BUCK1_BIT] |=> !irqOutN)
        else $error("unmasked buck1 not on pin");

    a_key_w1c: assert property (s_wr_one(STAT0_OFS, POWER_KEY_BIT)
        ##0 !(powerKeyPin && !$past(powerKeyPin)) |=> !stat0[POWER_KEY_BIT])
        else $error("power key flag not cleared");

endmodule : pfir_regs

`default_nettype wire

/* sim/pfir_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pfir_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid,
    output var  logic [7:0] regAddr,
    output var  logic       regWrEn,
    output var  logic [7:0] regWrData,
    output var  logic       regRdEn
);
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    // entered just after an edge; released values are inverted
    // an idle edge after each request keeps strobes from retoggling at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk);
        #1;
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
        @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk);
        #1;
        regRdEn = 1'b0;
        regAddr = ~a;
        n = 0;
        while (regRdValid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
        @(posedge clk);
        #1;
    endtask : rd
endmodule : pfir_host_model
`default_nettype wire

/* sim/test_pmic_fault_interrupt_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_pmic_fault_interrupt_regs;
    import pfir_pkg::*;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] regAddr, regWrData, regRdData;
    logic       regWrEn, regRdEn, regRdValid, irqOutN;
    logic       factoryTestPin = 1'b0;
    logic [3:0] tempAbove = 4'h0;
    logic       inputUndervolt = 1'b0;
    logic       powerKeyPin = 1'b0;
    logic [2:0] buckOvercurrent = 3'h0;
    logic       inputOvervolt = 1'b0;
    logic [5:0] linearOvercurrent = 6'h00;
    int         error_cnt = 0;
    int         compares = 0;
    int         cyc = 0;
    pfir_regs i_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .factoryTestPin(factoryTestPin), .tempAbove(tempAbove),
        .inputUndervolt(inputUndervolt), .powerKeyPin(powerKeyPin),
        .buckOvercurrent(buckOvercurrent), .inputOvervolt(inputOvervolt),
        .linearOvercurrent(linearOvercurrent), .irqOutN(irqOutN));
    pfir_host_model i_host (.clk(clk), .regRdData(regRdData),
        .regRdValid(regRdValid), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk($sformatf("reg %h", a), d, e);
    endtask : rc
    // irq settles two edges after its cause
    task automatic ic(input logic e);
        step(3);
        chk("irqOutN", {7'h00, irqOutN}, {7'h00, e});
    endtask : ic
    task automatic t_reset();
        logic [7:0] o [8];
        logic [7:0] e [8];
        o = '{MASK0_OFS, MASK1_OFS, MASK3_OFS, MASK4_OFS, STAT0_OFS,
              STAT1_OFS, STAT4_OFS, 8'h20};
        e = '{8'h3f, 8'h19, 8'h04, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rc(o[i], e[i]);
        end
        ic(1'b1);
    endtask : t_reset
    task automatic t_sense();
        factoryTestPin = 1'b1;
        tempAbove = 4'b0101;
        inputUndervolt = 1'b1;
        powerKeyPin = 1'b1;
        buckOvercurrent = 3'b101;
        inputOvervolt = 1'b1;
        step(1);
        rc(SENSE0_OFS, 8'h97);
        i_host.wr(SENSE0_OFS, 8'hff);
        rc(SENSE0_OFS, 8'h97);
        rc(SENSE1_OFS, 8'h11);
        rc(SENSE3_OFS, 8'h04);
        rc(STAT0_OFS, 8'h17);
        {factoryTestPin, tempAbove, inputUndervolt} = 6'h00;
        {buckOvercurrent, inputOvervolt} = 4'h0;
        step(2);
        rc(SENSE0_OFS, 8'h01);
    endtask : t_sense
    task automatic t_buck();
        rc(STAT1_OFS, 8'h11);
        i_host.wr(STAT1_OFS, 8'h00);
        rc(STAT1_OFS, 8'h11);
        ic(1'b1);
        i_host.wr(MASK1_OFS, 8'h00);
        ic(1'b0);
        i_host.wr(STAT1_OFS, 8'h01);
        rc(STAT1_OFS, 8'h10);
        ic(1'b0);
        i_host.wr(STAT1_OFS, 8'h10);
        ic(1'b1);
        buckOvercurrent = 3'b010;
        step(1);
        buckOvercurrent = 3'b000;
        rc(STAT1_OFS, 8'h08);
        ic(1'b0);
        i_host.wr(MASK1_OFS, 8'h08);
        ic(1'b1);
        i_host.wr(STAT1_OFS, 8'h08);
        i_host.wr(MASK1_OFS, 8'h19);
    endtask : t_buck
    task automatic t_ovlin();
        rc(STAT3_OFS, 8'h04);
        inputOvervolt = 1'b1;
        i_host.wr(STAT3_OFS, 8'h04);
        rc(STAT3_OFS, 8'h04);
        i_host.wr(MASK3_OFS, 8'h00);
        ic(1'b0);
        inputOvervolt = 1'b0;
        i_host.wr(STAT3_OFS, 8'h04);
        rc(STAT3_OFS, 8'h00);
        ic(1'b1);
        linearOvercurrent = 6'h3f;
        step(1);
        rc(SENSE4_OFS, 8'h3f);
        linearOvercurrent = 6'h00;
        rc(STAT4_OFS, 8'h3f);
        i_host.wr(STAT4_OFS, 8'h3f);
        rc(STAT4_OFS, 8'h00);
    endtask : t_ovlin
    task automatic t_therm();
        i_host.wr(STAT0_OFS, 8'h3f);
        for (int i = 0; i < 4; i++) begin
            tempAbove[i] = 1'b1;
            step(1);
            rc(STAT0_OFS, 8'h04 << i);
            i_host.wr(STAT0_OFS, 8'h3f);
            tempAbove[i] = 1'b0;
            step(1);
            rc(STAT0_OFS, 8'h04 << i);
            i_host.wr(STAT0_OFS, 8'h3f);
        end
        powerKeyPin = 1'b0;
        step(2);
        rc(STAT0_OFS, 8'h00);
    endtask : t_therm
    initial begin
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        step(2);
        t_reset();
        t_sense();
        t_buck();
        t_ovlin();
        t_therm();
        tally_and_finish();
    end
endmodule : test_pmic_fault_interrupt_regs
`default_nettype wire
